// ==== uece_pkg.sv ====
// Package for the endpoint zero control engine: register map, field
// positions, link encodings and the engine's state record.
// Assumes one clock domain and a 32-bit AXI4-Lite register bus.
package uece_pkg;

   // Register byte addresses
   localparam logic [7:0] A_INDEX = 8'h00;
   localparam logic [7:0] A_CSR = 8'h04;
   localparam logic [7:0] A_COUNT = 8'h08;
   localparam logic [7:0] A_FIFO = 8'h0C;
   localparam logic [7:0] INDEX_EP0 = 8'h00;
   localparam logic [7:0] INDEX_RST = 8'h00;

   // Control/status field positions
   localparam int F_OUT_RDY = 0;
   localparam int F_IN_RDY = 1;
   localparam int F_SENT_STALL = 2;
   localparam int F_DATA_END = 3;
   localparam int F_SETUP_END = 4;
   localparam int F_SEND_STALL = 5;
   localparam int F_SERV_OUT = 6;
   localparam int F_SERV_SETUP = 7;

   // Packet sizes
   localparam int MAX_PKT = 64;
   localparam logic [6:0] MAX_PKT_C = 7'h40;
   localparam logic [6:0] SETUP_LEN_C = 7'h08;

   // Token and handshake codes on the link side
   localparam logic [1:0] TOK_SETUP = 2'h0;
   localparam logic [1:0] TOK_IN = 2'h1;
   localparam logic [1:0] TOK_OUT = 2'h2;
   localparam logic [1:0] HS_ACK = 2'h0;
   localparam logic [1:0] HS_NAK = 2'h1;
   localparam logic [1:0] HS_STALL = 2'h2;

   // AXI responses
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX, ST_ACKW} uece_state_t;
   typedef enum logic [1:0] {RR_ACCEPT, RR_NAK, RR_STALL} uece_rxresp_t;

   typedef struct packed {
      logic valid;
      logic [1:0] code;
   } uece_hs_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic last;
      logic zlp;
   } uece_tx_t;

   typedef struct packed {
      uece_state_t state;
      uece_rxresp_t rx_resp;
      logic rx_setup;
      logic too_long;
      logic [MAX_PKT-1:0][7:0] mem;
      logic [5:0] wptr;
      logic [5:0] rptr;
      logic [6:0] count;
      logic [6:0] tx_len;
      logic [7:0] index;
      logic out_ready;
      logic in_ready;
      logic sent_stall;
      logic send_stall;
      logic setup_end;
      logic data_end;
      logic tx_mode;
      logic rx_mode;
      logic status_out;
      logic status_in;
      logic aw_held;
      logic w_held;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic wstrb0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      uece_hs_t hs;
      uece_tx_t tx;
      logic ep0_int;
   } uece_regs_t;

endpackage

// ==== uece_top.sv ====
// Endpoint zero control engine: token handling, handshakes, stall and
// setup-end detection, endpoint zero FIFO and its AXI4-Lite registers.
// Assumes a packet layer that decodes tokens, delivers checked data
// bytes and serialises the handshakes and data that this block emits.
//
// Summary of operation
// - Engine answers packets itself; interrupts only after a whole good packet, a stall sent or a setup-end.
// - Transmit interrupt only after packet sent and host handshake received.
// - Corrupted or erroneous packets never raise an interrupt.
// - Good OUT or SETUP data stored sets out-packet-ready and interrupts.
// - IN packet sent and acknowledged clears in-packet-ready and interrupts.
// - Completion of the status stage interrupts.
// - Transfer ending before data-end sets setup-end and interrupts.
// - Readable count of received bytes held in the FIFO.
// - Every stall sent sets sent-stall and interrupts.
// - Automatic stall on late OUT/IN, oversize packet, non-empty status data.
// - Firmware send-stall request makes the engine stall.
// - Only eight-byte SETUP data is accepted; others up to 64 bytes are dropped.
// - IN token with no packet ready gets NAK, and no interrupt outside receive mode.
// - First IN enters transmit mode; SETUP or OUT there sets setup-end.
// - Transmit mode ends on SETUP/OUT token or on a short packet sent.
// - First OUT enters receive mode; SETUP or IN there sets setup-end.
// - Receive mode ends on SETUP/IN token or a short received packet.
// - OUT after data-end in a control write is stalled and interrupts.
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module uece_top
   import uece_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic NRST,
   input wire logic CE,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [7:0] AWADDR,
   input wire logic WVALID,
   output logic WREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   output logic BVALID,
   input wire logic BREADY,
   output logic [1:0] BRESP,
   input wire logic ARVALID,
   output logic ARREADY,
   input wire logic [7:0] ARADDR,
   output logic RVALID,
   input wire logic RREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   input wire logic TOK_VALID,
   input wire logic [1:0] TOK_PID,
   input wire logic RX_VALID,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_END,
   input wire logic RX_ERR,
   output logic TX_VALID,
   output logic [7:0] TX_DATA,
   output logic TX_LAST,
   output logic TX_ZLP,
   input wire logic TX_READY,
   input wire logic HOST_ACK,
   output logic HS_VALID,
   output logic [1:0] HS_CODE,
   output logic EP0_INT
);

   uece_regs_t s;
   uece_regs_t n;
   logic wr_go;
   logic rd_go;
   logic ep0_sel;
   logic idle;
   logic conflict;
   logic ev;
   logic [7:0] csr_byte;

   assign AWREADY = s.awready;
   assign WREADY = s.wready;
   assign BVALID = s.bvalid;
   assign BRESP = s.bresp;
   assign ARREADY = s.arready;
   assign RVALID = s.rvalid;
   assign RDATA = s.rdata;
   assign RRESP = s.rresp;
   assign TX_VALID = s.tx.valid;
   assign TX_DATA = s.tx.data;
   assign TX_LAST = s.tx.last;
   assign TX_ZLP = s.tx.zlp;
   assign HS_VALID = s.hs.valid;
   assign HS_CODE = s.hs.code;
   assign EP0_INT = s.ep0_int;

   always_comb begin
      n = s;
      ev = 1'b0;
      n.hs.valid = 1'b0;
      wr_go = s.aw_held && s.w_held && !s.bvalid;
      rd_go = ARVALID && s.arready;
      ep0_sel = (s.index == INDEX_EP0);
      // Firmware FIFO access only while the link leaves the FIFO alone
      idle = (s.state == ST_IDLE);
      conflict = 1'b0;
      csr_byte = {2'b00, s.send_stall, s.setup_end, s.data_end,
                  s.sent_stall, s.in_ready, s.out_ready};

      // Bus write side
      if (AWVALID && s.awready) begin
         n.aw_held = 1'b1;
         n.awaddr = AWADDR;
      end
      if (WVALID && s.wready) begin
         n.w_held = 1'b1;
         n.wdata = WDATA;
         n.wstrb0 = WSTRB[0];
      end
      if (s.bvalid && BREADY) begin
         n.bvalid = 1'b0;
         n.aw_held = 1'b0;
         n.w_held = 1'b0;
      end
      if (wr_go) begin
         n.bvalid = 1'b1;
         n.bresp = AXI_OKAY;
         case (s.awaddr)
            A_INDEX: begin
               if (s.wstrb0) begin
                  n.index = s.wdata[7:0];
               end
            end
            A_CSR: begin
               if (s.wstrb0 && ep0_sel) begin
                  if (s.wdata[F_SERV_SETUP]) begin
                     n.setup_end = 1'b0;
                  end
                  if (s.wdata[F_SERV_OUT]) begin
                     n.out_ready = 1'b0;
                  end
                  n.send_stall = s.wdata[F_SEND_STALL];
                  if (s.wdata[F_DATA_END]) begin
                     n.data_end = 1'b1;
                  end
                  if (!s.wdata[F_SENT_STALL]) begin
                     n.sent_stall = 1'b0;
                  end
                  if (s.wdata[F_IN_RDY]) begin
                     n.in_ready = 1'b1;
                  end
               end
            end
            A_COUNT: begin
            end
            A_FIFO: begin
               if (s.wstrb0 && ep0_sel && idle && s.count != MAX_PKT_C) begin
                  n.mem[s.wptr] = s.wdata[7:0];
                  n.wptr = s.wptr + 6'h01;
                  n.count = s.count + 7'h01;
               end
            end
            default: begin
               n.bresp = AXI_SLVERR;
            end
         endcase
      end

      // Bus read side
      if (s.rvalid && RREADY) begin
         n.rvalid = 1'b0;
      end
      if (rd_go) begin
         n.rvalid = 1'b1;
         n.rresp = AXI_OKAY;
         n.rdata = 32'h00000000;
         case (ARADDR)
            A_INDEX: begin
               n.rdata = {24'h000000, s.index};
            end
            A_CSR: begin
               if (ep0_sel) begin
                  n.rdata = {24'h000000, csr_byte};
               end
            end
            A_COUNT: begin
               if (ep0_sel) begin
                  n.rdata = {25'h0000000, s.count};
               end
            end
            A_FIFO: begin
               if (ep0_sel && idle && s.count != 7'h00) begin
                  n.rdata = {24'h000000, s.mem[s.rptr]};
                  n.rptr = s.rptr + 6'h01;
                  n.count = s.count - 7'h01;
               end
            end
            default: begin
               n.rresp = AXI_SLVERR;
            end
         endcase
      end

      // Link side runs after the bus so hardware sets win over clears
      case (s.state)
         ST_IDLE: begin
            if (TOK_VALID) begin
               conflict = (TOK_PID == TOK_SETUP && (s.tx_mode || s.rx_mode))
                  || (TOK_PID == TOK_OUT && s.tx_mode)
                  || (TOK_PID == TOK_IN && s.rx_mode);
               if (conflict && !n.data_end) begin
                  n.setup_end = 1'b1;
                  ev = 1'b1;
               end
               if (TOK_PID != TOK_IN) begin
                  n.tx_mode = 1'b0;
               end
               if (TOK_PID != TOK_OUT) begin
                  n.rx_mode = 1'b0;
               end
               case (TOK_PID)
                  TOK_SETUP: begin
                     // A new setup discards whatever the FIFO held
                     n.state = ST_RX;
                     n.rx_resp = RR_ACCEPT;
                     n.rx_setup = 1'b1;
                     n.too_long = 1'b0;
                     n.wptr = 6'h00;
                     n.rptr = 6'h00;
                     n.count = 7'h00;
                     n.out_ready = 1'b0;
                     n.in_ready = 1'b0;
                     n.data_end = 1'b0;
                     n.status_out = 1'b0;
                     n.status_in = 1'b0;
                  end
                  TOK_OUT: begin
                     n.state = ST_RX;
                     n.rx_setup = 1'b0;
                     n.too_long = 1'b0;
                     if (s.send_stall) begin
                        n.rx_resp = RR_STALL;
                     end else if (s.status_out) begin
                        n.rx_resp = RR_ACCEPT;
                     end else if (n.data_end) begin
                        n.rx_resp = RR_STALL;
                     end else if (n.out_ready) begin
                        n.rx_resp = RR_NAK;
                     end else begin
                        n.rx_resp = RR_ACCEPT;
                        n.rx_mode = 1'b1;
                     end
                     if (n.rx_resp == RR_ACCEPT) begin
                        n.wptr = 6'h00;
                        n.rptr = 6'h00;
                        n.count = 7'h00;
                     end
                  end
                  TOK_IN: begin
                     if (s.send_stall || (s.tx_mode && n.data_end
                         && !n.in_ready)) begin
                        n.hs.valid = 1'b1;
                        n.hs.code = HS_STALL;
                        n.sent_stall = 1'b1;
                        ev = 1'b1;
                     end else if (n.in_ready) begin
                        n.state = ST_TX;
                        n.tx_mode = 1'b1;
                        n.status_in = 1'b0;
                        n.tx_len = n.count;
                        n.tx.valid = 1'b1;
                        n.tx.zlp = (n.count == 7'h00);
                        n.tx.last = (n.count <= 7'h01);
                        n.tx.data = n.mem[n.rptr];
                     end else if (n.data_end) begin
                        // Status stage of a write: empty packet
                        n.state = ST_TX;
                        n.status_in = 1'b1;
                        n.tx_len = 7'h00;
                        n.tx.valid = 1'b1;
                        n.tx.zlp = 1'b1;
                        n.tx.last = 1'b1;
                        n.tx.data = 8'h00;
                     end else begin
                        n.hs.valid = 1'b1;
                        n.hs.code = HS_NAK;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         ST_RX: begin
            if (RX_VALID && s.rx_resp == RR_ACCEPT) begin
               if (s.count == MAX_PKT_C) begin
                  n.too_long = 1'b1;
               end else begin
                  n.mem[s.wptr] = RX_DATA;
                  n.wptr = s.wptr + 6'h01;
                  n.count = s.count + 7'h01;
               end
            end
            if (RX_END) begin
               n.state = ST_IDLE;
               if (RX_ERR) begin
                  // Silent drop: host retries, firmware never sees it
                  if (s.rx_resp == RR_ACCEPT) begin
                     n.count = 7'h00;
                     n.wptr = 6'h00;
                  end
               end else if (s.rx_resp == RR_NAK) begin
                  n.hs.valid = 1'b1;
                  n.hs.code = HS_NAK;
               end else if (s.rx_resp == RR_STALL || s.too_long
                  || (s.status_out && s.count != 7'h00)) begin
                  n.hs.valid = 1'b1;
                  n.hs.code = HS_STALL;
                  n.sent_stall = 1'b1;
                  n.status_out = 1'b0;
                  n.rx_mode = 1'b0;
                  n.count = 7'h00;
                  n.wptr = 6'h00;
                  ev = 1'b1;
               end else if (s.rx_setup && s.count != SETUP_LEN_C) begin
                  n.count = 7'h00;
                  n.wptr = 6'h00;
               end else if (s.status_out) begin
                  n.hs.valid = 1'b1;
                  n.hs.code = HS_ACK;
                  n.status_out = 1'b0;
                  ev = 1'b1;
               end else begin
                  n.hs.valid = 1'b1;
                  n.hs.code = HS_ACK;
                  n.out_ready = 1'b1;
                  ev = 1'b1;
                  if (s.count != MAX_PKT_C) begin
                     n.rx_mode = 1'b0;
                  end
               end
            end
         end
         ST_TX: begin
            if (s.tx.valid && TX_READY) begin
               if (!s.tx.zlp) begin
                  n.rptr = s.rptr + 6'h01;
                  n.count = s.count - 7'h01;
               end
               if (s.tx.last) begin
                  n.tx.valid = 1'b0;
                  n.state = ST_ACKW;
               end else begin
                  n.tx.data = s.mem[n.rptr];
                  n.tx.last = (n.count == 7'h01);
               end
            end
         end
         ST_ACKW: begin
            if (HOST_ACK) begin
               n.state = ST_IDLE;
               ev = 1'b1;
               if (s.status_in) begin
                  n.status_in = 1'b0;
                  n.data_end = 1'b0;
               end else begin
                  n.in_ready = 1'b0;
                  if (s.tx_len != MAX_PKT_C) begin
                     n.tx_mode = 1'b0;
                  end
                  if (n.data_end) begin
                     n.data_end = 1'b0;
                     n.tx_mode = 1'b0;
                     n.status_out = 1'b1;
                  end
               end
            end else if (TOK_VALID) begin
               // Handshake lost: restore the packet so a retry resends it
               n.state = ST_IDLE;
               n.rptr = s.rptr - s.tx_len[5:0];
               n.count = s.tx_len;
            end
         end
         default: begin
            n.state = ST_IDLE;
         end
      endcase

      n.ep0_int = ev;
      n.awready = !n.aw_held;
      n.wready = !n.w_held;
      n.arready = !n.rvalid;
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         s <= '0;
      end else if (CE) begin
         s <= n;
      end
   end

endmodule

// ==== uece_chk.sv ====
// Port assertions for the endpoint zero engine.
// Assumes CE held high by the bench; bound onto uece_top below.
`timescale 1ns/1ns
module uece_chk
   import uece_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic NRST,
   input wire logic TOK_VALID,
   input wire logic RX_VALID,
   input wire logic RX_END,
   input wire logic RX_ERR,
   input wire logic HOST_ACK,
   input wire logic TX_VALID,
   input wire logic TX_READY,
   input wire logic [7:0] TX_DATA,
   input wire logic TX_LAST,
   input wire logic TX_ZLP,
   input wire logic HS_VALID,
   input wire logic [1:0] HS_CODE,
   input wire logic EP0_INT,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic [31:0] RDATA
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);
   property p_hs_pulse; HS_VALID |=> !HS_VALID; endproperty
   a_hs_pulse: assert property (p_hs_pulse)
      else $error("handshake too long");
   property p_hs_cause;
      HS_VALID |-> $past(RX_END) || $past(TOK_VALID) || $past(RX_VALID);
   endproperty
   a_hs_cause: assert property (p_hs_cause)
      else $error("handshake without cause");
   property p_err_quiet; RX_END && RX_ERR |=> !EP0_INT && !HS_VALID; endproperty
   a_err_quiet: assert property (p_err_quiet)
      else $error("bad packet answered");
   property p_nak_quiet; HS_VALID && HS_CODE == HS_NAK |-> !EP0_INT; endproperty
   a_nak_quiet: assert property (p_nak_quiet)
      else $error("interrupt on nak");
   property p_stall_int; HS_VALID && HS_CODE == HS_STALL |-> EP0_INT; endproperty
   a_stall_int: assert property (p_stall_int)
      else $error("stall without interrupt");
   property p_int_cause;
      EP0_INT |-> HS_VALID || $past(HOST_ACK) || $past(TOK_VALID);
   endproperty
   a_int_cause: assert property (p_int_cause)
      else $error("interrupt without cause");
   property p_tx_hold;
      TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST);
   endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("transmit byte dropped");
   property p_zlp_last; TX_VALID && TX_ZLP |-> TX_LAST; endproperty
   a_zlp_last: assert property (p_zlp_last)
      else $error("empty packet not last");
   property p_r_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped");
   c_stall: cover property (HS_VALID && HS_CODE == HS_STALL);
   c_nak: cover property (HS_VALID && HS_CODE == HS_NAK);
   c_in_done: cover property (HOST_ACK ##1 EP0_INT);
endmodule
bind uece_top uece_chk u_chk (.CORE_CLK(CORE_CLK), .NRST(NRST),
   .TOK_VALID(TOK_VALID), .RX_VALID(RX_VALID), .RX_END(RX_END),
   .RX_ERR(RX_ERR), .HOST_ACK(HOST_ACK), .TX_VALID(TX_VALID),
   .TX_READY(TX_READY), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST),
   .TX_ZLP(TX_ZLP), .HS_VALID(HS_VALID), .HS_CODE(HS_CODE),
   .EP0_INT(EP0_INT), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA));

// ==== uece_host.sv ====
// Behavioural host on the link side: tokens, data packets, IN capture.
// Assumes the bench fills pk before sending and calls tasks after an edge.
`timescale 1ns/1ns
module uece_host
   import uece_pkg::*;
(
   input wire logic clk,
   output logic tok_valid,
   output logic [1:0] tok_pid,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_end,
   output logic rx_err,
   output logic tx_ready,
   output logic host_ack,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   input wire logic tx_zlp
);
   logic [7:0] pk [0:64];
   logic [7:0] got [0:64];
   initial begin
      {tok_valid, rx_valid, rx_end, rx_err, tx_ready, host_ack} = '0;
      {tok_pid, rx_data} = '0;
   end
   task tok(input logic [1:0] pid);
      tok_valid <= 1'b1;
      tok_pid <= pid;
      @(posedge clk);
      tok_valid <= 1'b0;
      tok_pid <= ~pid;
   endtask
   // Zero length allowed; ends exact-multiple writes
   task pkt(input int n, input logic err);
      for (int i = 0; i < n; i++) begin
         rx_valid <= 1'b1;
         rx_data <= pk[i];
         @(posedge clk);
      end
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
      rx_end <= 1'b1;
      rx_err <= err;
      @(posedge clk);
      rx_end <= 1'b0;
      rx_err <= ~err;
   endtask
   task take(output int n, output logic z);
      int t;
      n = 0;
      z = 1'b0;
      t = 0;
      // Late ready so the transmit hold is exercised
      @(posedge clk);
      tx_ready <= 1'b1;
      do begin
         @(posedge clk);
         t++;
         if (tx_valid === 1'b1 && tx_zlp === 1'b1)
            z = 1'b1;
         else if (tx_valid === 1'b1)
            got[n++] = tx_data;
      end while (!(tx_valid === 1'b1 && tx_last === 1'b1) && t < 300);
      tx_ready <= 1'b0;
      host_ack <= 1'b1;
      @(posedge clk);
      host_ack <= 1'b0;
   endtask
endmodule

// ==== uece_top_test.sv ====
// Self-checking bench: AXI4-Lite firmware tasks plus the host model.
// Assumes the register map and link timing of the engine's hand-over.
`timescale 1ns/1ns
module uece_top_test
   import uece_pkg::*;
;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, seed = 32'h00007A10;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, hs_code, tok_pid, hs_c, r;
   logic [31:0] rdata, d;
   logic tok_valid, rx_valid, rx_end, rx_err, tx_ready, host_ack;
   logic tx_valid, tx_last, tx_zlp, hs_valid, ep0_int;
   logic [7:0] rx_data, tx_data;
   int n_mismatch = 0, n_compared = 0, hs_n = 0, int_n = 0, h0 = 0, i0 = 0;
   always #20 clk = ~clk;
   uece_top u_dut (.CORE_CLK(clk), .NRST(nrst), .CE(1'b1),
      .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
      .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
      .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
      .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready),
      .RDATA(rdata), .RRESP(rresp), .TOK_VALID(tok_valid), .TOK_PID(tok_pid),
      .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_END(rx_end),
      .RX_ERR(rx_err), .TX_VALID(tx_valid), .TX_DATA(tx_data),
      .TX_LAST(tx_last), .TX_ZLP(tx_zlp), .TX_READY(tx_ready),
      .HOST_ACK(host_ack), .HS_VALID(hs_valid), .HS_CODE(hs_code),
      .EP0_INT(ep0_int));
   uece_host u_host (.clk(clk), .tok_valid(tok_valid), .tok_pid(tok_pid),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
      .rx_err(rx_err), .tx_ready(tx_ready), .host_ack(host_ack),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
      .tx_zlp(tx_zlp));
   always @(posedge clk) begin
      if (hs_valid === 1'b1) begin
         hs_n <= hs_n + 1;
         hs_c <= hs_code;
      end
      if (ep0_int === 1'b1)
         int_n <= int_n + 1;
   end
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task summarize;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task timeout;
      chk("wait limit", 1, 0);
      summarize();
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      int t;
      logic ao, wo;
      {t, ao, wo} = '0;
      {awvalid, wvalid, awaddr, wdata} <= {2'b11, a, v};
      while (!(ao && wo) && t++ < 50) begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         ao |= awready;
         wo |= wready;
      end
      bready <= 1'b1;
      while (bvalid !== 1'b1 && t++ < 100) @(posedge clk);
      bready <= 1'b0;
      if (t >= 100) timeout();
   endtask
   task rd(input logic [7:0] a);
      int t;
      t = 0;
      arvalid <= 1'b1;
      araddr <= a;
      do @(posedge clk); while (arready !== 1'b1 && t++ < 50);
      arvalid <= 1'b0;
      // Late ready so the read-data hold is exercised
      @(posedge clk);
      rready <= 1'b1;
      do @(posedge clk); while (rvalid !== 1'b1 && t++ < 100);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
      if (t >= 100) timeout();
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      rd(a);
      chk("register", e, d & m);
      chk("read resp", AXI_OKAY, r);
   endtask
   // Link answers come a cycle after their cause; three cycles is ample
   task expect_ev(input int dh, input int di, input logic [1:0] c);
      repeat (3) @(posedge clk);
      chk("handshakes", dh, hs_n - h0);
      chk("interrupts", di, int_n - i0);
      if (dh > 0) chk("hs code", c, hs_c);
      h0 = hs_n;
      i0 = int_n;
   endtask
   task fill(input int n);
      for (int i = 0; i < n; i++) u_host.pk[i] = rnd();
   endtask
   task drain(input int n);
      for (int i = 0; i < n; i++) begin
         rd(A_FIFO);
         chk("fifo byte", {24'h0, u_host.pk[i]}, d);
      end
      rchk(A_COUNT, 0, 32'hFF);
   endtask
   task setup8;
      fill(8);
      u_host.tok(TOK_SETUP);
      u_host.pkt(8, 1'b0);
      expect_ev(1, 1, HS_ACK);
      rchk(A_CSR, 32'h1, 32'hFF);
      rchk(A_COUNT, 8, 32'hFF);
      drain(8);
      wr(A_CSR, 32'h40);
      rchk(A_CSR, 0, 32'h1);
   endtask
   task inx(input int n, input logic [31:0] f = 32'h2);
      int m;
      logic z;
      fill(n);
      for (int i = 0; i < n; i++) wr(A_FIFO, {24'h0, u_host.pk[i]});
      wr(A_CSR, f);
      u_host.tok(TOK_IN);
      u_host.take(m, z);
      expect_ev(0, 1, HS_ACK);
      chk("tx count", n, m);
      chk("tx empty", n == 0, z);
      for (int i = 0; i < n; i++) chk("tx byte", u_host.pk[i], u_host.got[i]);
      rchk(A_CSR, 0, 32'h2);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      rchk(A_INDEX, INDEX_RST, 32'hFF);
      rchk(A_COUNT, 0, 32'hFFFFFFFF);
      rd(8'h10);
      chk("unmapped resp", AXI_SLVERR, r);
      wr(A_INDEX, 32'h1);
      wr(A_CSR, 32'h20);
      wr(A_INDEX, INDEX_EP0);
      rchk(A_CSR, 0, 32'hFF);
      setup8();
      fill(7);
      u_host.tok(TOK_SETUP);
      u_host.pkt(7, 1'b0);
      expect_ev(0, 0, HS_ACK);
      u_host.tok(TOK_SETUP);
      u_host.pkt(8, 1'b1);
      expect_ev(0, 0, HS_ACK);
      u_host.tok(TOK_IN);
      expect_ev(1, 0, HS_NAK);
      inx(0);
      inx(rnd() % 63 + 1);
      inx(rnd() % 63 + 1, 32'hA);
      u_host.tok(TOK_OUT);
      u_host.pkt(0, 1'b0);
      expect_ev(1, 1, HS_ACK);
      rchk(A_CSR, 0, 32'h19);
      wr(A_CSR, 32'h40);
      setup8();
      inx(64);
      u_host.tok(TOK_OUT);
      u_host.pkt(0, 1'b0);
      repeat (3) @(posedge clk);
      chk("setup end int", 1, int_n > i0);
      rchk(A_CSR, 32'h10, 32'h10);
      h0 = hs_n;
      i0 = int_n;
      wr(A_CSR, 32'hC0);
      rchk(A_CSR, 0, 32'h10);
      wr(A_CSR, 32'h20);
      u_host.tok(TOK_IN);
      expect_ev(1, 1, HS_STALL);
      rchk(A_CSR, 32'h24, 32'h24);
      wr(A_CSR, 32'h0);
      rchk(A_CSR, 0, 32'h24);
      setup8();
      fill(65);
      u_host.tok(TOK_OUT);
      u_host.pkt(65, 1'b0);
      expect_ev(1, 1, HS_STALL);
      wr(A_CSR, 32'h0);
      setup8();
      fill(64);
      u_host.tok(TOK_OUT);
      u_host.pkt(64, 1'b0);
      expect_ev(1, 1, HS_ACK);
      drain(64);
      wr(A_CSR, 32'h48);
      u_host.tok(TOK_OUT);
      u_host.pkt(4, 1'b0);
      expect_ev(1, 1, HS_STALL);
      rchk(A_CSR, 32'h4, 32'h4);
      summarize();
   end
endmodule
